/* verilog/gfs_pkg.sv */
// Purpose: shared constants and types of the earth-leak setpoint bank
// Assumes: 16-bit setpoint words addressed by an 8-bit index
// Notes:   reset values without a printed default are plain picks
package gfs_pkg;

    // ------------------------------------------------------------
    // setpoint indices
    // ------------------------------------------------------------
    localparam logic [7:0] GFS_IDX_INST  = 8'h11;
    localparam logic [7:0] GFS_IDX_DET   = 8'h12;
    localparam logic [7:0] GFS_IDX_FUNC  = 8'h13;
    localparam logic [7:0] GFS_IDX_WAVE  = 8'h14;
    localparam logic [7:0] GFS_IDX_GFP   = 8'h15;
    localparam logic [7:0] GFS_IDX_DLY   = 8'h16;
    localparam logic [7:0] GFS_IDX_THERM = 8'h17;
    localparam logic [7:0] GFS_IDX_NEU   = 8'h18;
    localparam logic [7:0] GFS_IDX_UAL   = 8'h19;
    localparam logic [7:0] GFS_IDX_PRE   = 8'h1A;

    // ------------------------------------------------------------
    // code ranges and fixed values
    // ------------------------------------------------------------
    localparam logic [15:0] GFS_INST_MIN    = 16'h0014;
    localparam logic [15:0] GFS_INST_MAX    = 16'h00B4;
    localparam logic [15:0] GFS_DET_VALUE   = 16'h0000;
    localparam logic [15:0] GFS_GFP_MIN     = 16'h0014;
    localparam logic [15:0] GFS_GFP_MAX     = 16'h0064;
    localparam logic [15:0] GFS_DLY_MAX     = 16'h0064;
    localparam logic [15:0] GFS_BIT_MAX     = 16'h0001;
    localparam logic [15:0] GFS_NEU_ZERO    = 16'h0000;
    localparam logic [15:0] GFS_NEU_MID     = 16'h003C;
    localparam logic [15:0] GFS_NEU_FULL    = 16'h0064;
    localparam logic [15:0] GFS_UAL_MIN     = 16'h0032;
    localparam logic [15:0] GFS_UAL_MAX_STD = 16'h0082;
    localparam logic [15:0] GFS_UAL_MAX_MOT = 16'h0078;
    localparam logic [15:0] GFS_UAL_FIXED   = 16'h0069;
    localparam logic [15:0] GFS_PRE_MIN     = 16'h0032;
    localparam logic [15:0] GFS_PRE_MAX     = 16'h0064;
    localparam logic [15:0] GFS_PRE_STEP    = 16'h0005;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GFS_RST_INST  = 8'h64;
    localparam logic       GFS_RST_WAVE  = 1'b0;
    localparam logic [6:0] GFS_RST_GFP   = 7'h14;
    localparam logic [6:0] GFS_RST_DLY   = 7'h00;
    localparam logic       GFS_RST_THERM = 1'b1;
    localparam logic [6:0] GFS_RST_NEU   = 7'h64;
    localparam logic [7:0] GFS_RST_UAL   = 8'h64;
    localparam logic [6:0] GFS_RST_PRE   = 7'h32;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GFS_FUNC_TRIP  = 2'b00,
        GFS_FUNC_ALARM = 2'b01,
        GFS_FUNC_OFF   = 2'b10
    } gfs_func_t;

    typedef enum logic [1:0] {
        GFS_VAR_BASIC    = 2'b00,
        GFS_VAR_STANDARD = 2'b01,
        GFS_VAR_MOTOR    = 2'b10
    } gfs_variant_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [7:0]  idx;
        logic [15:0] wdata;
    } gfs_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } gfs_rsp_t;

    typedef struct packed {
        logic [7:0] inst_pickup;
        gfs_func_t  func;
        logic       wave;
        logic [6:0] gfp;
        logic [6:0] dly;
        logic       therm;
        logic [6:0] neutral;
        logic [7:0] upper_alarm;
        logic [6:0] prealarm;
    } gfs_set_t;

endpackage : gfs_pkg

/* verilog/gfs_code_check.sv */
// Purpose: decides whether a setpoint write carries a legal code
// Assumes: current function code and lower alarm come from flops
// Notes:   purely combinational; unmapped indices flag mapped_o low
`timescale 1ns/1ps
`default_nettype none
module gfs_code_check
    import gfs_pkg::*;
(
    input  wire gfs_pkg::gfs_req_t     req_i,
    input  wire gfs_pkg::gfs_variant_t variant_i,
    input  wire gfs_pkg::gfs_func_t    func_i,
    input  wire logic [15:0]           lower_alarm_i,
    output logic                       write_ok_o,
    output logic                       mapped_o
);

    logic [15:0] v;
    logic        basic;
    logic [15:0] ual_max;

    assign v       = req_i.wdata;
    assign basic   = (variant_i == GFS_VAR_BASIC);
    assign ual_max = (variant_i == GFS_VAR_MOTOR) ? GFS_UAL_MAX_MOT
                                                  : GFS_UAL_MAX_STD;

    // per-index legality of the written code
    always_comb begin
        write_ok_o = 1'b0;
        mapped_o   = 1'b1;
        case (req_i.idx)
            GFS_IDX_INST: write_ok_o = !basic && v >= GFS_INST_MIN
                                       && v <= GFS_INST_MAX;
            GFS_IDX_DET:  write_ok_o = 1'b0;
            GFS_IDX_FUNC: write_ok_o = v <= 16'(GFS_FUNC_OFF);
            GFS_IDX_WAVE: write_ok_o = v <= GFS_BIT_MAX;
            GFS_IDX_GFP:  write_ok_o = !basic && v >= GFS_GFP_MIN
                                       && v <= GFS_GFP_MAX;
            GFS_IDX_DLY:  write_ok_o = !basic && v <= GFS_DLY_MAX;
            GFS_IDX_THERM: write_ok_o = v <= GFS_BIT_MAX;
            GFS_IDX_NEU:  write_ok_o = v == GFS_NEU_ZERO
                                       || v == GFS_NEU_MID
                                       || v == GFS_NEU_FULL;
            GFS_IDX_UAL:  write_ok_o = !basic && v >= GFS_UAL_MIN
                                       && v <= ual_max
                                       && v > lower_alarm_i;
            GFS_IDX_PRE:  write_ok_o = func_i == GFS_FUNC_TRIP
                                       && v >= GFS_PRE_MIN
                                       && v <= GFS_PRE_MAX
                                       && (v % GFS_PRE_STEP) == 16'h0000;
            default: begin
                write_ok_o = 1'b0;
                mapped_o   = 1'b0;
            end
        endcase
    end

endmodule : gfs_code_check
`default_nettype wire

/* verilog/gfs_setpoint_bank.sv */
// Purpose: indexed setpoint bank for earth-leak and alarm settings
// Assumes: fieldbus side issues one request per cycle at most
// Notes:   answers one cycle after a request; rejected writes keep data
`timescale 1ns/1ps
`default_nettype none
module gfs_setpoint_bank
    import gfs_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire gfs_pkg::gfs_req_t     req_i,
    input  wire gfs_pkg::gfs_variant_t variant_i,
    input  wire logic [15:0]           lower_alarm_i,
    output gfs_pkg::gfs_rsp_t          rsp_o,
    output gfs_pkg::gfs_set_t          settings_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        gfs_rsp_t rsp;
        gfs_set_t set;
    } gfs_state_t;

    localparam gfs_state_t GFS_STATE_RST = '{
        rsp: '{ack: 1'b0, err: 1'b0, rdata: 16'h0000},
        set: '{inst_pickup: GFS_RST_INST,
               func:        GFS_FUNC_TRIP,
               wave:        GFS_RST_WAVE,
               gfp:         GFS_RST_GFP,
               dly:         GFS_RST_DLY,
               therm:       GFS_RST_THERM,
               neutral:     GFS_RST_NEU,
               upper_alarm: GFS_RST_UAL,
               prealarm:    GFS_RST_PRE}
    };

    gfs_state_t  st_reg;
    gfs_state_t  st_next;
    logic        write_ok;
    logic        mapped;
    logic [15:0] rd_val;

    // ------------------------------------------------------------
    // code legality
    // ------------------------------------------------------------
    gfs_code_check u_check (
        .req_i         (req_i),
        .variant_i     (variant_i),
        .func_i        (st_reg.set.func),
        .lower_alarm_i (lower_alarm_i),
        .write_ok_o    (write_ok),
        .mapped_o      (mapped)
    );

    // ------------------------------------------------------------
    // read-back multiplexer
    // ------------------------------------------------------------
    // stored fields zero-extended to the 16-bit word
    always_comb begin
        rd_val = 16'h0000;
        case (req_i.idx)
            GFS_IDX_INST:  rd_val = 16'(st_reg.set.inst_pickup);
            GFS_IDX_DET:   rd_val = GFS_DET_VALUE;
            GFS_IDX_FUNC:  rd_val = 16'(st_reg.set.func);
            GFS_IDX_WAVE:  rd_val = 16'(st_reg.set.wave);
            GFS_IDX_GFP:   rd_val = 16'(st_reg.set.gfp);
            GFS_IDX_DLY:   rd_val = 16'(st_reg.set.dly);
            GFS_IDX_THERM: rd_val = 16'(st_reg.set.therm);
            GFS_IDX_NEU:   rd_val = 16'(st_reg.set.neutral);
            GFS_IDX_UAL:   rd_val = 16'(st_reg.set.upper_alarm);
            GFS_IDX_PRE:   rd_val = 16'(st_reg.set.prealarm);
            default:       rd_val = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // one request per cycle; answer registered for the next cycle
    always_comb begin
        st_next           = st_reg;
        st_next.rsp.ack   = 1'b0;
        st_next.rsp.err   = 1'b0;
        st_next.rsp.rdata = 16'h0000;
        if (req_i.valid) begin
            st_next.rsp.ack = 1'b1;
            if (!req_i.wr) begin
                st_next.rsp.err   = !mapped;
                st_next.rsp.rdata = rd_val;
            end else if (!write_ok) begin
                st_next.rsp.err = 1'b1;
            end else begin
                case (req_i.idx)
                    GFS_IDX_INST:
                        st_next.set.inst_pickup = req_i.wdata[7:0];
                    GFS_IDX_FUNC:
                        st_next.set.func =
                            gfs_func_t'(req_i.wdata[1:0]);
                    GFS_IDX_WAVE:
                        st_next.set.wave = req_i.wdata[0];
                    GFS_IDX_GFP:
                        st_next.set.gfp = req_i.wdata[6:0];
                    GFS_IDX_DLY:
                        st_next.set.dly = req_i.wdata[6:0];
                    GFS_IDX_THERM:
                        st_next.set.therm = req_i.wdata[0];
                    GFS_IDX_NEU:
                        st_next.set.neutral = req_i.wdata[6:0];
                    GFS_IDX_UAL:
                        st_next.set.upper_alarm = req_i.wdata[7:0];
                    GFS_IDX_PRE:
                        st_next.set.prealarm = req_i.wdata[6:0];
                    default:
                        st_next.set = st_reg.set;
                endcase
            end
        end
        // basic variant pins the upper alarm level
        if (variant_i == GFS_VAR_BASIC) begin
            st_next.set.upper_alarm = GFS_UAL_FIXED[7:0];
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // clock enable low freezes everything, answer included
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= GFS_STATE_RST;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign rsp_o      = st_reg.rsp;
    assign settings_o = st_reg.set;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // a request taken at this edge
    sequence s_take(logic [7:0] ix, logic w);
        ce_i && req_i.valid && req_i.idx == ix && req_i.wr == w;
    endsequence

    // a write taken at this edge that the checker accepts
    sequence s_good_wr(logic [7:0] ix);
        s_take(ix, 1'b1) ##0 write_ok;
    endsequence

    property p_inst_range;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_INST) |=>
            16'(settings_o.inst_pickup) >= GFS_INST_MIN
            && 16'(settings_o.inst_pickup) <= GFS_INST_MAX
            && settings_o.inst_pickup == $past(req_i.wdata[7:0]);
    endproperty
    a_inst_range: assert property (p_inst_range)
        else $error("instantaneous pickup stored out of range");

    property p_det_zero;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_DET, 1'b0) |=>
            rsp_o.ack && !rsp_o.err && rsp_o.rdata == GFS_DET_VALUE;
    endproperty
    a_det_zero: assert property (p_det_zero)
        else $error("detection type did not read zero");

    property p_func_legal;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_FUNC, 1'b1) ##0 (req_i.wdata > 16'h0002) |=>
            rsp_o.err && $stable(settings_o.func);
    endproperty
    a_func_legal: assert property (p_func_legal)
        else $error("illegal function code accepted");

    property p_wave_bit;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_WAVE, 1'b0) |=>
            rsp_o.rdata[15:1] == 15'h0000;
    endproperty
    a_wave_bit: assert property (p_wave_bit)
        else $error("waveform read-back wider than one bit");

    property p_gfp_range;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_GFP, 1'b1) ##0
            (req_i.wdata < GFS_GFP_MIN || req_i.wdata > GFS_GFP_MAX)
            |=> rsp_o.err;
    endproperty
    a_gfp_range: assert property (p_gfp_range)
        else $error("earth-leak pickup outside 20..100 accepted");

    property p_dly_range;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_DLY) |=>
            16'(settings_o.dly) <= GFS_DLY_MAX && !rsp_o.err;
    endproperty
    a_dly_range: assert property (p_dly_range)
        else $error("earth-leak delay stored above 100");

    property p_therm_write;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_THERM) |=>
            settings_o.therm == $past(req_i.wdata[0]) ##1
            (!ce_i || !req_i.valid || req_i.idx != GFS_IDX_THERM
             || settings_o.therm == $past(settings_o.therm));
    endproperty
    a_therm_write: assert property (p_therm_write)
        else $error("thermal memory did not follow accepted write");

    property p_neu_set;
        @(posedge core_clk_i) disable iff (rst_i)
        $changed(settings_o.neutral) |->
            16'(settings_o.neutral) == GFS_NEU_ZERO
            || 16'(settings_o.neutral) == GFS_NEU_MID
            || 16'(settings_o.neutral) == GFS_NEU_FULL;
    endproperty
    a_neu_set: assert property (p_neu_set)
        else $error("neutral percent left the allowed set");

    property p_ual_range;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_UAL) ##0 (variant_i == GFS_VAR_MOTOR) |=>
            16'(settings_o.upper_alarm) <= GFS_UAL_MAX_MOT
            && 16'(settings_o.upper_alarm) >= GFS_UAL_MIN;
    endproperty
    a_ual_range: assert property (p_ual_range)
        else $error("upper alarm above motor variant limit");

    property p_ual_fixed;
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && variant_i == GFS_VAR_BASIC)[*3] |->
            16'(settings_o.upper_alarm) == GFS_UAL_FIXED;
    endproperty
    a_ual_fixed: assert property (p_ual_fixed)
        else $error("basic variant upper alarm not fixed at 105");

    property p_pre_gate;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_PRE, 1'b1) ##0
            (st_reg.set.func != GFS_FUNC_TRIP) |=>
            rsp_o.err && $stable(settings_o.prealarm);
    endproperty
    a_pre_gate: assert property (p_pre_gate)
        else $error("pre-alarm accepted while function not trip");

    property p_ual_order;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_UAL, 1'b1) ##0
            (req_i.wdata <= lower_alarm_i) |=> rsp_o.err;
    endproperty
    a_ual_order: assert property (p_ual_order)
        else $error("upper alarm not above lower alarm accepted");

    property p_reject_keep;
        @(posedge core_clk_i) disable iff (rst_i)
        ce_i && req_i.valid && req_i.wr && !write_ok
            && variant_i != GFS_VAR_BASIC |=>
            rsp_o.ack && rsp_o.err && $stable(settings_o);
    endproperty
    a_reject_keep: assert property (p_reject_keep)
        else $error("rejected write changed a setting");

    property p_det_ro;
        @(posedge core_clk_i) disable iff (rst_i)
        s_take(GFS_IDX_DET, 1'b1) |=> rsp_o.ack && rsp_o.err;
    endproperty
    a_det_ro: assert property (p_det_ro)
        else $error("write to detection type accepted");

    property p_wave_store;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_WAVE) |=>
            settings_o.wave == $past(req_i.wdata[0]) && !rsp_o.err;
    endproperty
    a_wave_store: assert property (p_wave_store)
        else $error("waveform did not take the accepted bit");

    property p_gfp_store;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_GFP) |=>
            settings_o.gfp == $past(req_i.wdata[6:0]);
    endproperty
    a_gfp_store: assert property (p_gfp_store)
        else $error("earth-leak pickup did not take the accepted code");

    property p_ual_std;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_UAL) ##0 (variant_i == GFS_VAR_STANDARD) |=>
            16'(settings_o.upper_alarm) <= GFS_UAL_MAX_STD
            && settings_o.upper_alarm == $past(req_i.wdata[7:0]);
    endproperty
    a_ual_std: assert property (p_ual_std)
        else $error("upper alarm above standard variant limit");

    property p_pre_step;
        @(posedge core_clk_i) disable iff (rst_i)
        s_good_wr(GFS_IDX_PRE) |=>
            (16'(settings_o.prealarm) % GFS_PRE_STEP) == 16'h0000
            && 16'(settings_o.prealarm) >= GFS_PRE_MIN
            && 16'(settings_o.prealarm) <= GFS_PRE_MAX;
    endproperty
    a_pre_step: assert property (p_pre_step)
        else $error("pre-alarm stored off the five percent grid");

    property p_unmapped;
        @(posedge core_clk_i) disable iff (rst_i)
        ce_i && req_i.valid && !mapped |=>
            rsp_o.ack && rsp_o.err && rsp_o.rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped index answered without error");

    // answer exactly one enabled edge after a request
    property p_ack_pulse;
        @(posedge core_clk_i) disable iff (rst_i)
        ce_i |=> rsp_o.ack == $past(req_i.valid);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("answer did not follow the request by one cycle");

    // clock enable low holds answer and settings
    property p_ce_freeze;
        @(posedge core_clk_i) disable iff (rst_i)
        !ce_i |=> $stable(rsp_o) && $stable(settings_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable was low");

endmodule : gfs_setpoint_bank
`default_nettype wire

/* testbench/gfs_master_model.sv */
// Purpose: fieldbus master model issuing indexed setpoint requests
// Assumes: one request per transfer, answer within three cycles
// Notes:   released request fields show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module gfs_master_model
    import gfs_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire gfs_pkg::gfs_rsp_t rsp_i,
    output var  gfs_pkg::gfs_req_t req_o
);
    import gfs_pkg::*;

    // idle bus at time zero
    initial begin
        req_o = '0;
    end

    // ------------------------------------------------------------
    // one transfer: request for one edge, then wait for the answer
    // ------------------------------------------------------------
    task automatic xfer(
        input  logic        wr,
        input  logic [7:0]  idx,
        input  logic [15:0] wd,
        output logic        ack,
        output logic        err,
        output logic [15:0] rd
    );
        ack = 1'b0;
        err = 1'b0;
        rd  = 16'h0000;
        @(posedge core_clk_i);
        req_o <= '{valid: 1'b1, wr: wr, idx: idx, wdata: wd};
        @(posedge core_clk_i);
        // taken at this edge; drop valid, scramble the stale fields
        req_o <= '{valid: 1'b0, wr: ~wr, idx: ~idx, wdata: ~wd};
        for (int k = 0; k < 3 && !ack; k++) begin
            #1;
            if (rsp_i.ack === 1'b1) begin
                ack = 1'b1;
                err = rsp_i.err;
                rd  = rsp_i.rdata;
            end else begin
                @(posedge core_clk_i);
            end
        end
    endtask : xfer
endmodule : gfs_master_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench of the earth-leak setpoint bank
// Assumes: standard variant first, basic variant after a second reset
// Notes:   a shadow copy of every mapped entry predicts its read-backs
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gfs_pkg::*;

    logic         core_clk_i;
    logic         rst_i;
    logic         ce_i;
    gfs_req_t     req;
    gfs_variant_t variant;
    logic [15:0]  lower_alarm;
    gfs_rsp_t     rsp;
    gfs_set_t     settings;
    logic [15:0]  shadow [8'h11:8'h1A];
    int           fail_count;
    int           num_checks;
    logic         ce_ack;
    logic         ce_err;
    logic [15:0]  ce_rd;

    gfs_setpoint_bank i_gfs_setpoint_bank (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .req_i         (req),
        .variant_i     (variant),
        .lower_alarm_i (lower_alarm),
        .rsp_o         (rsp),
        .settings_o    (settings)
    );

    gfs_master_model i_gfs_master_model (
        .core_clk_i (core_clk_i),
        .rsp_i      (rsp),
        .req_o      (req)
    );

    // 250 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------
    // check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [15:0] wd, input logic exp_err,
                        output logic [15:0] rd);
        logic ack;
        logic err;
        i_gfs_master_model.xfer(wr, idx, wd, ack, err, rd);
        chk({15'h0000, ack}, 16'h0001);
        chk({15'h0000, err}, {15'h0000, exp_err});
    endtask : xfer

    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp,
                          input logic exp_err);
        logic [15:0] rd;
        xfer(1'b0, idx, 16'h0000, exp_err, rd);
        chk(rd, exp_err ? 16'h0000 : exp);
    endtask : rd_chk

    // write, then read back against the shadow copy
    task automatic wr_chk(input logic [7:0] idx, input logic [15:0] val,
                          input logic exp_err);
        logic [15:0] rd;
        xfer(1'b1, idx, val, exp_err, rd);
        chk(rd, 16'h0000);
        if (idx >= 8'h11 && idx <= 8'h1A) begin
            if (!exp_err) shadow[idx] = val;
            rd_chk(idx, shadow[idx], 1'b0);
        end
    endtask : wr_chk

    task automatic reset_shadow(input logic [15:0] ual);
        shadow = '{16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0014,
                   16'h0000, 16'h0001, 16'h0064, ual, 16'h0032};
    endtask : reset_shadow

    task automatic rd_all;
        for (int i = 8'h11; i <= 8'h1A; i++) begin
            rd_chk(i[7:0], shadow[i], 1'b0);
        end
    endtask : rd_all

    task automatic summarize;
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_i       = 1'b1;
        ce_i        = 1'b1;
        variant     = GFS_VAR_STANDARD;
        lower_alarm = 16'h003C;
        fail_count  = 0;
        num_checks  = 0;
        reset_shadow(16'h0064);
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_all();
        // range edges of every writable entry but the pre-alarm
        wr_chk(8'h11, 16'h0013, 1'b1);
        wr_chk(8'h11, 16'h0014, 1'b0);
        wr_chk(8'h11, 16'h00B4, 1'b0);
        wr_chk(8'h11, 16'h00B5, 1'b1);
        wr_chk(8'h12, 16'h0001, 1'b1);
        wr_chk(8'h13, 16'h0003, 1'b1);
        wr_chk(8'h13, 16'h0002, 1'b0);
        chk({14'h0000, settings.func}, 16'h0002);
        wr_chk(8'h13, 16'h0001, 1'b0);
        wr_chk(8'h13, 16'h0000, 1'b0);
        wr_chk(8'h14, 16'h0002, 1'b1);
        wr_chk(8'h14, 16'h0001, 1'b0);
        wr_chk(8'h15, 16'h0013, 1'b1);
        wr_chk(8'h15, 16'h0065, 1'b1);
        wr_chk(8'h15, 16'h0064, 1'b0);
        wr_chk(8'h16, 16'h0065, 1'b1);
        wr_chk(8'h16, 16'h0064, 1'b0);
        chk({9'h000, settings.dly}, 16'h0064);
        wr_chk(8'h16, 16'h0000, 1'b0);
        wr_chk(8'h17, 16'h0002, 1'b1);
        wr_chk(8'h17, 16'h0000, 1'b0);
        chk({15'h0000, settings.therm}, 16'h0000);
        wr_chk(8'h17, 16'h0001, 1'b0);
        wr_chk(8'h18, 16'h003D, 1'b1);
        wr_chk(8'h18, 16'h003C, 1'b0);
        wr_chk(8'h18, 16'h0000, 1'b0);
        wr_chk(8'h19, 16'h0082, 1'b0);
        wr_chk(8'h19, 16'h0083, 1'b1);
        wr_chk(8'h19, 16'h0031, 1'b1);
        wr_chk(8'h19, 16'h003C, 1'b1);
        wr_chk(8'h19, 16'h003D, 1'b0);
        // pre-alarm steps, bounds and function gate
        wr_chk(8'h1A, 16'h0037, 1'b0);
        wr_chk(8'h1A, 16'h0039, 1'b1);
        wr_chk(8'h1A, 16'h0069, 1'b1);
        wr_chk(8'h1A, 16'h002D, 1'b1);
        wr_chk(8'h1A, 16'h0064, 1'b0);
        wr_chk(8'h13, 16'h0001, 1'b0);
        wr_chk(8'h1A, 16'h003C, 1'b1);
        wr_chk(8'h13, 16'h0000, 1'b0);
        wr_chk(8'h20, 16'h0001, 1'b1);
        rd_chk(8'h20, 16'h0000, 1'b1);
        // clock enable low: the request is ignored, nothing moves
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        i_gfs_master_model.xfer(1'b1, 8'h17, 16'h0000, ce_ack, ce_err,
                                ce_rd);
        chk({15'h0000, ce_ack}, 16'h0000);
        chk({15'h0000, settings.therm}, 16'h0001);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        rd_chk(8'h17, 16'h0001, 1'b0);
        // motor variant narrows the upper alarm range
        @(posedge core_clk_i);
        variant     <= GFS_VAR_MOTOR;
        lower_alarm <= 16'h0050;
        wr_chk(8'h19, 16'h0079, 1'b1);
        wr_chk(8'h19, 16'h0078, 1'b0);
        wr_chk(8'h19, 16'h0050, 1'b1);
        // basic variant after a second reset: upper alarm fixed
        @(posedge core_clk_i);
        variant <= GFS_VAR_BASIC;
        rst_i   <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        reset_shadow(16'h0069);
        rd_all();
        wr_chk(8'h19, 16'h006E, 1'b1);
        wr_chk(8'h11, 16'h0032, 1'b1);
        summarize();
    end

    // hang guard, about forty times the expected run
    initial begin
        #40000;
        fail_count++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
